// ===== sacc_defines.svh
// Timing, field and count constants for the serial converter control block.
`ifndef SACC_DEFINES_SVH
`define SACC_DEFINES_SVH

// Master clock rate in hertz.
`define SACC_MCLK_HZ 20000000
// Period of one internal conversion clock step in nanoseconds.
`define SACC_ICLK_NS 500
// Master clock cycles per internal step, rounded up.
`define SACC_ICLK_CYC ((`SACC_ICLK_NS * (`SACC_MCLK_HZ / 1000000) + 999) / 1000)

// Control byte bit counts, start bit being count one.
`define SACC_CNT_START 4'h1
`define SACC_CNT_CHANNEL_SELECT_MSB 4'h1
`define SACC_CNT_SEL1 4'h2
`define SACC_CNT_SEL0 4'h3
`define SACC_CNT_POL 4'h4
`define SACC_CNT_CFG 4'h5
`define SACC_CNT_PDHI 4'h6
`define SACC_CNT_PDLO 4'h7
`define SACC_CNT_TRACK 4'h5
`define SACC_CNT_HOLD 4'h8

// Power and clock mode field value that selects the external clock.
`define SACC_MODE_EXT 2'h3

// Successive approximation starting code and mask.
`define SACC_SAR_MID 10'h200
`define SACC_SAR_LSB 10'h001

// Reset values of the input multiplexer.
`define SACC_CH_RESET 8'h01
`define SACC_CH_NONE 8'h00

`endif

// ===== sacc_pkg.sv
// Types shared by the serial converter control modules.
package sacc_pkg;

    // Control sequencer states, one-hot.
    typedef enum logic [4:0] {
        st_idle = 5'h01,
        st_shift = 5'h02,
        st_conv_ext = 5'h04,
        st_conv_int = 5'h08,
        st_drain = 5'h10
    } sacc_state_type;

endpackage

// ===== sacc_sar_if.sv
// Interface between the control sequencer and the approximation register.
`timescale 1ns/1ns
interface sacc_sar_if;
    logic start; // One-cycle pulse that opens a conversion.
    logic step; // One-cycle pulse that makes one bit decision.
    logic comp; // Comparator verdict, high keeps the trial bit.
    logic done; // One-cycle pulse after the last decision.
    logic [9:0] code; // Trial code driving the capacitive DAC.
    logic [9:0] result; // Final code, valid from the done pulse.

    modport ctrl (output start, output step, output comp, input done, input code, input result);
    modport sar (input start, input step, input comp, output done, output code, output result);
endinterface

// ===== sacc_sar.sv
// Ten-bit successive approximation register.
`timescale 1ns/1ns
`include "sacc_defines.svh"
module sacc_sar (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    sacc_sar_if.sar sar
);

    logic [9:0] mask; // One-hot pointer at the bit under trial.
    logic [9:0] kept; // Trial code with the current decision applied.

    // A low verdict drops the bit under trial.
    assign kept = sar.comp ? sar.code : (sar.code & ~mask);

    // Trial code and pointer walk from the top bit to the bottom bit.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sar.code <= `SACC_SAR_MID;
            mask <= `SACC_SAR_MID;
        end else if (sar.start) begin
            sar.code <= `SACC_SAR_MID;
            mask <= `SACC_SAR_MID;
        end else if (sar.step) begin
            sar.code <= kept | (mask >> 1);
            mask <= mask >> 1;
        end
    end

    // The last decision latches the result and raises done once.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sar.done <= 1'b0;
            sar.result <= 10'h000;
        end else begin
            sar.done <= 1'b0;
            if (sar.step && mask == `SACC_SAR_LSB) begin
                sar.done <= 1'b1;
                sar.result <= kept;
            end
        end
    end

endmodule

// ===== sacc_top.sv
// Control and serial interface of an eight-channel ten-bit converter.
`timescale 1ns/1ns
`include "sacc_defines.svh"
module sacc_top (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic cs_b_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic comp_i,
    input wire logic three_level_shutdown_low_i,
    input wire logic three_level_shutdown_high_i,
    output logic dout_o,
    output logic dout_oe_b_o,
    output logic conversion_strobe_o,
    output logic conversion_strobe_oe_b_o,
    output logic track_o,
    output logic [7:0] pos_channel_o,
    output logic [7:0] neg_channel_o,
    output logic neg_com_o,
    output logic [9:0] dac_code_o,
    output logic polarity_select_o,
    output logic shutdown_o,
    output logic ext_comp_o,
    output logic power_down_o,
    output logic [9:0] result_o,
    output logic result_valid_o
);

    // Synchroniser chains; the first stage feeds only the second.
    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2;
    logic din_s1, din_s2;
    logic comp_s1, comp_s2;
    logic low_s1, low_s2;
    logic high_s1, high_s2;

    sacc_pkg::sacc_state_type state; // Sequencer state.
    logic [3:0] bit_cnt; // Control bits taken since the start bit.
    logic [3:0] div_cnt; // Internal conversion clock divider.
    logic [2:0] channel_select; // Channel select field, top bit first.
    logic polarity_select; // High selects unipolar coding.
    logic input_config_select; // High selects single-ended inputs.
    logic power_clock_mode_hi; // Upper bit of the mode field.
    logic power_clock_mode_lo; // Lower bit of the mode field.
    logic ext_mode; // Conversion in progress runs on the serial clock.
    logic [9:0] out_sr; // Result bits waiting to leave on the data output.

    sacc_sar_if sar_bus ();

    logic sclk_rise, sclk_fall, cs_act;
    logic ev_hold, iclk_tick;
    logic [2:0] pos_idx, neg_idx;

    // Edges of the synchronised serial clock.
    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign sclk_fall = ~sclk_s2 & sclk_s3;
    assign cs_act = ~cs_s2;
    // The falling edge after the eighth control bit ends acquisition.
    assign ev_hold = (state == sacc_pkg::st_shift) && sclk_fall && (bit_cnt == `SACC_CNT_HOLD);
    assign iclk_tick = (state == sacc_pkg::st_conv_int) && (div_cnt == 4'(`SACC_ICLK_CYC - 1));
    // Single-ended order is select bits one, zero, then two; pairs flip the low bit.
    assign pos_idx = {channel_select[1], channel_select[0], channel_select[2]};
    assign neg_idx = {channel_select[1], channel_select[0], ~channel_select[2]};

    // Converter drive toward the approximation register.
    assign sar_bus.start = ev_hold;
    assign sar_bus.step = ((state == sacc_pkg::st_conv_ext) && sclk_fall) || iclk_tick;
    assign sar_bus.comp = comp_s2;
    assign dac_code_o = sar_bus.code;

    sacc_sar u_sar (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .sar(sar_bus)
    );

    // Two-stage synchronisers for every pin; the clock gets a third stage for edges.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
            low_s1 <= 1'b0;
            low_s2 <= 1'b0;
            high_s1 <= 1'b0;
            high_s2 <= 1'b0;
        end else begin
            sclk_s1 <= sclk_i;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1 <= cs_b_i;
            cs_s2 <= cs_s1;
            din_s1 <= din_i;
            din_s2 <= din_s1;
            comp_s1 <= comp_i;
            comp_s2 <= comp_s1;
            low_s1 <= three_level_shutdown_low_i;
            low_s2 <= low_s1;
            high_s1 <= three_level_shutdown_high_i;
            high_s2 <= high_s1;
        end
    end

    // Three-level shutdown decode; low wins, neither level means floating.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shutdown_o <= 1'b1;
            ext_comp_o <= 1'b0;
        end else begin
            shutdown_o <= low_s2;
            ext_comp_o <= ~low_s2 & ~high_s2;
        end
    end

    // Sequencer: start bit search, control byte, conversion and drain.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= sacc_pkg::st_idle;
            bit_cnt <= 4'h0;
        end else if (low_s2) begin
            state <= sacc_pkg::st_idle;
            bit_cnt <= 4'h0;
        end else begin
            case (state)
                sacc_pkg::st_idle, sacc_pkg::st_drain: begin
                    // Zeros before the first one are ignored.
                    if (cs_act && sclk_rise && din_s2) begin
                        state <= sacc_pkg::st_shift;
                        bit_cnt <= `SACC_CNT_START;
                    end else if (!cs_act) begin
                        state <= sacc_pkg::st_idle;
                    end
                end
                sacc_pkg::st_shift: begin
                    if (!cs_act) begin
                        state <= sacc_pkg::st_idle;
                    end else if (ev_hold) begin
                        state <= ({power_clock_mode_hi, power_clock_mode_lo} == `SACC_MODE_EXT) ?
                            sacc_pkg::st_conv_ext : sacc_pkg::st_conv_int;
                    end else if (sclk_rise && bit_cnt < `SACC_CNT_HOLD) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                sacc_pkg::st_conv_ext: begin
                    // A deselect aborts a conversion paced by the serial clock.
                    if (!cs_act) begin
                        state <= sacc_pkg::st_idle;
                    end else if (sar_bus.done) begin
                        state <= sacc_pkg::st_drain;
                    end
                end
                sacc_pkg::st_conv_int: begin
                    // The internal conversion finishes regardless of chip select.
                    if (sar_bus.done) begin
                        state <= sacc_pkg::st_drain;
                    end
                end
                default: begin
                    state <= sacc_pkg::st_idle;
                end
            endcase
        end
    end

    // Control byte fields, captured by position as each bit arrives.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            channel_select <= 3'h0;
            polarity_select <= 1'b1;
            input_config_select <= 1'b1;
            power_clock_mode_hi <= 1'b1;
            power_clock_mode_lo <= 1'b1;
        end else if (state == sacc_pkg::st_shift && cs_act && sclk_rise) begin
            case (bit_cnt)
                `SACC_CNT_CHANNEL_SELECT_MSB: channel_select[2] <= din_s2;
                `SACC_CNT_SEL1: channel_select[1] <= din_s2;
                `SACC_CNT_SEL0: channel_select[0] <= din_s2;
                `SACC_CNT_POL: polarity_select <= din_s2;
                `SACC_CNT_CFG: input_config_select <= din_s2;
                `SACC_CNT_PDHI: power_clock_mode_hi <= din_s2;
                `SACC_CNT_PDLO: power_clock_mode_lo <= din_s2;
                default: begin
                end
            endcase
        end
    end

    // Track and hold switch and the input multiplexer.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            track_o <= 1'b0;
            pos_channel_o <= `SACC_CH_RESET;
            neg_channel_o <= `SACC_CH_NONE;
            neg_com_o <= 1'b1;
        end else begin
            if (low_s2) begin
                track_o <= 1'b0;
            end else if (state == sacc_pkg::st_shift && sclk_fall && bit_cnt == `SACC_CNT_TRACK) begin
                track_o <= 1'b1;
            end else if (ev_hold) begin
                track_o <= 1'b0;
            end else if (sar_bus.done) begin
                track_o <= 1'b1;
            end
            // The multiplexer follows the byte only until hold.
            if (state == sacc_pkg::st_shift) begin
                pos_channel_o <= 8'h01 << pos_idx;
                neg_channel_o <= input_config_select ? `SACC_CH_NONE : (8'h01 << neg_idx);
                neg_com_o <= input_config_select;
            end
        end
    end

    // Mode flags and the result as seen by the system.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_mode <= 1'b1;
            polarity_select_o <= 1'b1;
            power_down_o <= 1'b0;
            result_o <= 10'h000;
            result_valid_o <= 1'b0;
        end else begin
            if (ev_hold) begin
                ext_mode <= ({power_clock_mode_hi, power_clock_mode_lo} == `SACC_MODE_EXT);
                polarity_select_o <= polarity_select;
                power_down_o <= ~power_clock_mode_hi;
                result_valid_o <= 1'b0;
            end else if (sar_bus.done) begin
                // Bipolar results leave in two's complement.
                result_o <= {sar_bus.result[9] ^ ~polarity_select_o, sar_bus.result[8:0]};
                result_valid_o <= 1'b1;
            end
        end
    end

    // Internal conversion clock divider.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt <= 4'h0;
        end else if (state != sacc_pkg::st_conv_int || iclk_tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // Serial data output, changing only on serial clock falls.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dout_o <= 1'b0;
            dout_oe_b_o <= 1'b1;
            out_sr <= 10'h000;
        end else begin
            dout_oe_b_o <= cs_s2;
            if (ev_hold) begin
                dout_o <= 1'b0;
                out_sr <= 10'h000;
            end else if (state == sacc_pkg::st_conv_ext && sclk_fall) begin
                dout_o <= comp_s2 ^ ~polarity_select_o & (sar_bus.code == `SACC_SAR_MID);
            end else if (sar_bus.done && !ext_mode) begin
                out_sr <= {sar_bus.result[9] ^ ~polarity_select_o, sar_bus.result[8:0]};
            end else if (state == sacc_pkg::st_drain && sclk_fall && cs_act) begin
                dout_o <= out_sr[9];
                out_sr <= {out_sr[8:0], 1'b0};
            end
        end
    end

    // Conversion strobe in both clock modes.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conversion_strobe_o <= 1'b0;
            conversion_strobe_oe_b_o <= 1'b1;
        end else begin
            conversion_strobe_oe_b_o <= ext_mode & cs_s2;
            if (ev_hold) begin
                conversion_strobe_o <= ({power_clock_mode_hi, power_clock_mode_lo} == `SACC_MODE_EXT);
            end else if (state == sacc_pkg::st_conv_ext && sclk_fall) begin
                conversion_strobe_o <= 1'b0;
            end else if (sar_bus.done && !ext_mode) begin
                conversion_strobe_o <= 1'b1;
            end
        end
    end

endmodule

// ===== sacc_asserts.sv
// Concurrent checks on the pins of the converter control block.
`timescale 1ns/1ns
module sacc_asserts (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic cs_b_i,
    input wire logic sclk_i,
    input wire logic three_level_shutdown_low_i,
    input wire logic three_level_shutdown_high_i,
    input wire logic dout_o,
    input wire logic dout_oe_b_o,
    input wire logic conversion_strobe_o,
    input wire logic conversion_strobe_oe_b_o,
    input wire logic track_o,
    input wire logic [7:0] pos_channel_o,
    input wire logic [7:0] neg_channel_o,
    input wire logic neg_com_o,
    input wire logic shutdown_o,
    input wire logic ext_comp_o,
    input wire logic [9:0] result_o,
    input wire logic result_valid_o
);
    // Every check runs on the master clock and rests during reset.
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // Neighbour of each positive channel, the only legal negative input.
    logic [7:0] pair;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            pair[k] = pos_channel_o[k ^ 1];
        end
    end
    a_dout_release: assert property (cs_b_i [*4] |-> dout_oe_b_o)
        else $error("data out still driven after deselect");
    a_dout_on_fall: assert property ($changed(dout_o) && !cs_b_i |-> !$past(sclk_i))
        else $error("data out moved away from a serial clock fall");
    a_strobe_release: assert property (conversion_strobe_oe_b_o |-> $past(cs_b_i, 3))
        else $error("strobe released while selected");
    a_ext_strobe_pulse: assert property ($rose(conversion_strobe_o) && $fell(track_o)
        |=> conversion_strobe_o [*7] ##1 !conversion_strobe_o)
        else $error("external strobe pulse not one serial period");
    a_int_strobe_low: assert property ($fell(conversion_strobe_o) && $fell(track_o)
        |=> !conversion_strobe_o [*8] ##[80:150] conversion_strobe_o)
        else $error("internal strobe not low for the conversion");
    a_track_again: assert property ($rose(result_valid_o) |-> ##[0:2] track_o)
        else $error("no tracking after conversion end");
    a_result_moves: assert property ($changed(result_o) |-> $rose(result_valid_o))
        else $error("result changed without a new conversion");
    a_single_com: assert property (neg_com_o |-> neg_channel_o == 8'h00 && $onehot(pos_channel_o))
        else $error("single-ended routing wrong");
    a_diff_pair: assert property (!neg_com_o |-> neg_channel_o == pair && $onehot(pos_channel_o))
        else $error("differential pair not adjacent");
    a_three_level_shutdown_low: assert property (three_level_shutdown_low_i [*5] |-> shutdown_o)
        else $error("low shutdown level ignored");
    a_three_level_shutdown_float: assert property ((!three_level_shutdown_low_i && !three_level_shutdown_high_i) [*5] |-> ext_comp_o && !shutdown_o)
        else $error("floating shutdown level misread");
    // A switch of the track and hold that is neither a conversion end nor a shutdown follows a clock fall four edges back.
    a_track_on_fall: assert property ($rose(track_o) && !$rose(result_valid_o)
        |-> $past(sclk_i, 4) && !$past(sclk_i, 3))
        else $error("tracking began away from a serial clock fall");
    a_hold_on_fall: assert property ($fell(track_o) && !shutdown_o
        |-> $past(sclk_i, 4) && !$past(sclk_i, 3))
        else $error("hold began away from a serial clock fall");
endmodule

// ===== sacc_host_model.sv
// Serial master model with idle-low clock, data taken on rises.
`timescale 1ns/1ns
module sacc_host_model (
    input wire logic mclk_i,
    input wire logic dout_i,
    input wire logic dout_oe_b_i,
    input wire logic strobe_i,
    output logic cs_b_o = 1'b1,
    output logic sclk_o = 1'b0,
    output logic din_o = 1'b0,
    output logic [15:0] word_o = 16'h0000,
    output logic word_stb_o = 1'b0
);
    // One bit: data set in the low phase, clock high, data out read a cycle later.
    task automatic clk_bit(input logic b, output logic q);
        din_o <= b;
        repeat (4) @(posedge mclk_i);
        sclk_o <= 1'b1;
        @(posedge mclk_i);
        q = dout_oe_b_i ? 1'bx : dout_i;
        repeat (3) @(posedge mclk_i);
        sclk_o <= 1'b0;
    endtask
    // Whole frame: leading zeros, control byte, then sixteen read clocks.
    task automatic xfer(input logic [7:0] cmd, input int lead, input logic ext);
        logic q;
        logic [15:0] w;
        cs_b_o <= 1'b0;
        repeat (4) @(posedge mclk_i);
        repeat (lead) clk_bit(1'b0, q);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(cmd[i], q);
            // Stretch the low phase after the fifth bit so that tracking lasts past 1.5 us.
            if (i == 3) repeat (8) @(posedge mclk_i);
        end
        if (!ext) repeat (8) @(posedge mclk_i);
        for (int n = 0; !ext && strobe_i !== 1'b1 && n < 400; n++) @(posedge mclk_i);
        for (int i = 15; i >= 0; i--) begin
            clk_bit(1'b0, q);
            w[i] = q;
        end
        cs_b_o <= 1'b1;
        din_o <= ~din_o;
        word_o <= w;
        word_stb_o <= 1'b1;
        @(posedge mclk_i);
        word_stb_o <= 1'b0;
        repeat (8) @(posedge mclk_i);
    endtask
endmodule

// ===== sacc_tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
module testbench;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cs_b_i, sclk_i, din_i;
    logic comp_i = 1'b0;
    logic three_level_shutdown_low_i = 1'b0;
    logic three_level_shutdown_high_i = 1'b1;
    logic dout_o, dout_oe_b_o, conversion_strobe_o, conversion_strobe_oe_b_o, track_o;
    logic [7:0] pos_channel_o, neg_channel_o;
    logic neg_com_o, polarity_select_o, shutdown_o, ext_comp_o, power_down_o, result_valid_o;
    logic [9:0] dac_code_o, result_o;
    logic [9:0] vin = 10'h000; // Analog level seen by the comparator.
    logic [15:0] word;
    logic word_stb, valid_q;
    logic [9:0] exp_res[$]; // Expected conversion codes, oldest first.
    logic [14:0] exp_word[$]; // Expected serial words, oldest first.
    int miscompares = 0;
    int total_checks = 0;
    always #25 mclk_i = ~mclk_i;
    sacc_top sacc_top_inst (.mclk_i, .rst_b_i, .cs_b_i, .sclk_i, .din_i, .comp_i, .three_level_shutdown_low_i,
        .three_level_shutdown_high_i, .dout_o, .dout_oe_b_o, .conversion_strobe_o, .conversion_strobe_oe_b_o,
        .track_o, .pos_channel_o, .neg_channel_o, .neg_com_o, .dac_code_o, .polarity_select_o,
        .shutdown_o, .ext_comp_o, .power_down_o, .result_o, .result_valid_o);
    sacc_host_model sacc_host_model_inst (.mclk_i, .dout_i(dout_o), .dout_oe_b_i(dout_oe_b_o),
        .strobe_i(conversion_strobe_o), .cs_b_o(cs_b_i), .sclk_o(sclk_i), .din_o(din_i),
        .word_o(word), .word_stb_o(word_stb));
    // Comparator model: high while the input is at or above the trial code.
    always @(posedge mclk_i) comp_i <= (vin >= dac_code_o);
    // Shared tally for every comparison.
    task automatic tally(input logic ok, input string what);
        total_checks++;
        if (!ok) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic cmp_res(input logic [9:0] got, input logic [9:0] exp);
        tally(got === exp, "conversion code");
    endtask
    task automatic cmp_word(input logic [14:0] got, input logic [14:0] exp);
        tally(got === exp, "serial result word");
    endtask
    task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
        tally(got === exp, "static output");
    endtask
    // Watcher: each new result or finished frame is matched to the oldest note.
    always @(posedge mclk_i) begin
        valid_q <= result_valid_o;
        if (result_valid_o === 1'b1 && valid_q === 1'b0) cmp_res(result_o, exp_res.pop_front());
        if (word_stb === 1'b1) cmp_word(word[14:0], exp_word.pop_front());
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog sized well beyond the expected run of about 125 us.
    initial begin
        #1000000;
        miscompares++;
        conclude();
    end
    // Main sequence: deselected clocks, a mode sweep on random channels, shutdown levels.
    initial begin
        logic q;
        logic [2:0] idx;
        logic [1:0] mode;
        logic pol, cfg;
        logic [9:0] v, r;
        void'($urandom(32'h2bc8c472));
        repeat (4) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        repeat (8) sacc_host_model_inst.clk_bit(1'b1, q);
        cmp_pin({7'h00, track_o}, 8'h00);
        $display("test deselected clocks done");
        for (int i = 0; i < 8; i++) begin
            idx = 3'($urandom);
            pol = 1'($urandom);
            cfg = 1'($urandom);
            mode = 2'h3 - 2'(i);
            v = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($urandom);
            vin <= v;
            r = pol ? v : v ^ 10'h200;
            exp_res.push_back(r);
            exp_word.push_back({r, 5'h00});
            sacc_host_model_inst.xfer({1'b1, idx[0], idx[2], idx[1], pol, cfg, mode},
                int'($urandom_range(3)), mode == 2'h3);
            cmp_pin(pos_channel_o, 8'h01 << idx);
            cmp_pin(neg_channel_o, cfg ? 8'h00 : 8'h01 << (idx ^ 3'h1));
            cmp_pin({6'h00, neg_com_o, polarity_select_o}, {6'h00, cfg, pol});
            cmp_pin({7'h00, power_down_o}, {7'h00, ~mode[1]});
            // Internal mode leaves the strobe high and driven; external mode leaves it low and released.
            cmp_pin({6'h00, conversion_strobe_oe_b_o, conversion_strobe_o}, {6'h00, mode == 2'h3, mode != 2'h3});
            $display("test conversion %0d mode %0d done", i, mode);
        end
        for (int k = 0; k < 3; k++) begin
            three_level_shutdown_low_i <= (k == 0);
            three_level_shutdown_high_i <= (k == 2);
            repeat (6) @(posedge mclk_i);
            cmp_pin({6'h00, shutdown_o, ext_comp_o}, {6'h00, k == 0, k == 1});
        end
        three_level_shutdown_high_i <= 1'b1;
        $display("test shutdown levels done");
        conclude();
    end
endmodule
bind sacc_top sacc_asserts sacc_asserts_inst (.mclk_i, .rst_b_i, .cs_b_i, .sclk_i, .three_level_shutdown_low_i,
    .three_level_shutdown_high_i, .dout_o, .dout_oe_b_o, .conversion_strobe_o, .conversion_strobe_oe_b_o, .track_o,
    .pos_channel_o, .neg_channel_o, .neg_com_o, .shutdown_o, .ext_comp_o, .result_o, .result_valid_o);
